//--- verilog/hwrc_map.svh
// offsets, field positions, reset values and timing counts of the
// sleep, wake-up and reset controller.
// assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef HWRC_MAP_SVH
`define HWRC_MAP_SVH

// ============================================================
// register byte offsets
`define HWRC_OFF_CTRL       8'h00
`define HWRC_OFF_STATUS     8'h04
`define HWRC_OFF_CFG_BASE   8'h08
`define HWRC_CFG_COUNT      7

// ============================================================
// control register fields
`define HWRC_CTRL_WAKE_LSB  0
`define HWRC_CTRL_WAKE_MSB  7
`define HWRC_CTRL_WDOSC     8

// ============================================================
// status register fields
`define HWRC_ST_EXPIRY      0
`define HWRC_ST_SLEEP       1
`define HWRC_ST_STATE_LSB   2
`define HWRC_ST_STATE_MSB   4
`define HWRC_ST_CAUSE_LSB   5
`define HWRC_ST_CAUSE_MSB   6

// ============================================================
// interrupt control fields (global enable, then per-source enables)
`define HWRC_INT_GLOBAL     0
`define HWRC_INT_EN_LSB     1
`define HWRC_INT_EN_MSB     3

// ============================================================
// reset values and writable bits of the reset-state registers
`define HWRC_RST_TIMER      8'h08
`define HWRC_RST_CONV       8'h40
`define HWRC_RST_AMP        8'h08
`define HWRC_RST_INT        8'h00
`define HWRC_RST_PDATA      8'hff
`define HWRC_RST_PDIR       8'hff
`define HWRC_RST_PCLOW      8'h00
`define HWRC_MASK_TIMER     8'hdf
`define HWRC_MASK_INT       8'h7f
`define HWRC_MASK_FULL      8'hff
`define HWRC_RST_CTRL       9'h000

// ============================================================
// timing, in system clock cycles
`define HWRC_SST_CYCLES     1024
`define HWRC_OPT_CYCLES     16

`endif

//--- verilog/hwrc_pkg.sv
// types shared by the sleep, wake-up and reset controller.
// assumes hwrc_map.svh holds the register map, reset values and timing counts; the state and cause encodings are held here.
`default_nettype none
package hwrc_pkg;

    // controller phase
    typedef enum logic [2:0] {
        HWRC_OPTLOAD   = 3'b000,
        HWRC_STARTUP   = 3'b001,
        HWRC_RUN       = 3'b010,
        HWRC_SLEEP     = 3'b011,
        HWRC_IRQ_DELAY = 3'b100
    } hwrc_state_t;

    // cause of the last restart
    typedef enum logic [1:0] {
        HWRC_CAUSE_FULL = 2'b00,
        HWRC_CAUSE_NEXT = 2'b01,
        HWRC_CAUSE_IRQ  = 2'b10,
        HWRC_CAUSE_WARM = 2'b11
    } hwrc_cause_t;

endpackage
`default_nettype wire

//--- verilog/hwrc_top.sv
// sleep, wake-up and reset controller of a small 8-bit core.
// assumes sys_clk never stops; the gated system oscillator is modelled
// by osc_run, and core, watchdog and interrupt logic sit on sys_clk.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hwrc_map.svh"
module hwrc_top #(
    parameter int OPT_CYCLES = `HWRC_OPT_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        external_clear_pin_n,
    input  wire logic [7:0]  port_a_in,
    input  wire logic        sleep_instruction,
    input  wire logic        clear_watchdog_instruction,
    input  wire logic        watchdog_overflow,
    input  wire logic [2:0]  irq_request,
    input  wire logic        stack_full,
    output var  logic        osc_run,
    output var  logic        core_hold,
    output var  logic        full_reset,
    output var  logic        warm_reset,
    output var  logic        watchdog_clear,
    output var  logic        resume_next,
    output var  logic        irq_ack,
    output var  logic        sleep_flag,
    output var  logic        watchdog_expiry_flag
);
    localparam int          SST_CYCLES = `HWRC_SST_CYCLES;
    localparam logic [10:0] SST_LAST   = 11'(SST_CYCLES - 1);
    localparam logic [10:0] OPT_LAST   = 11'(OPT_CYCLES - 1);
    localparam int          N_CFG      = `HWRC_CFG_COUNT;
    localparam int          CFG_TIMER  = 0;
    localparam int          CFG_INT    = 3;
    localparam int          CFG_PCLOW  = 6;
    localparam logic [7:0]  CFG_RST [N_CFG] = '{`HWRC_RST_TIMER, `HWRC_RST_CONV, `HWRC_RST_AMP,
        `HWRC_RST_INT, `HWRC_RST_PDATA, `HWRC_RST_PDIR, `HWRC_RST_PCLOW};
    localparam logic [7:0]  CFG_MASK [N_CFG] = '{`HWRC_MASK_TIMER, `HWRC_MASK_FULL, `HWRC_MASK_FULL,
        `HWRC_MASK_INT, `HWRC_MASK_FULL, `HWRC_MASK_FULL, `HWRC_MASK_FULL};
    hwrc_pkg::hwrc_state_t state;
    hwrc_pkg::hwrc_cause_t cause;
    logic [10:0] cnt;
    logic        clr_s1, clr_s2;
    logic [7:0]  pa_s1, pa_s2, pa_s3, pa_fall;
    logic [8:0]  ctrl;
    logic [7:0]  cfg [N_CFG];
    logic [2:0]  irq_mask, irq_new;
    logic        ext_clr, go_full, go_sleep, go_warm, wake_irq, wake_port, sst_done, irq_go;
    logic        wr_pend, rd_pend;
    logic [7:0]  addr_q;
    logic [31:0] rd_mux;
    // ============================================================
    // pin synchronisers: pins are asynchronous; the clear pin is read at stage two, port A at stages two and three for edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clr_s1 <= 1'b1;
            clr_s2 <= 1'b1;
            pa_s1  <= 8'hff;
            pa_s2  <= 8'hff;
            pa_s3  <= 8'hff;
        end else begin
            clr_s1 <= external_clear_pin_n;
            clr_s2 <= clr_s1;
            pa_s1  <= port_a_in;
            pa_s2  <= pa_s1;
            pa_s3  <= pa_s2;
        end
    end
    // ============================================================
    // event decode
    assign ext_clr   = ~clr_s2;
    assign pa_fall   = pa_s3 & ~pa_s2 & ctrl[`HWRC_CTRL_WAKE_MSB:`HWRC_CTRL_WAKE_LSB];
    assign irq_new   = irq_request & ~irq_mask;
    assign go_full   = ext_clr | (state == hwrc_pkg::HWRC_RUN && watchdog_overflow);
    assign go_sleep  = state == hwrc_pkg::HWRC_RUN && !go_full && sleep_instruction;
    assign go_warm   = state == hwrc_pkg::HWRC_SLEEP && !ext_clr && watchdog_overflow;
    assign wake_irq  = state == hwrc_pkg::HWRC_SLEEP && !ext_clr && !watchdog_overflow && |irq_new;
    assign wake_port = state == hwrc_pkg::HWRC_SLEEP && !ext_clr && !watchdog_overflow && |pa_fall;
    assign sst_done  = state == hwrc_pkg::HWRC_STARTUP && osc_run && cnt == SST_LAST;
    // service only when globally and individually enabled and the stack has room
    assign irq_go    = cause == hwrc_pkg::HWRC_CAUSE_IRQ && cfg[CFG_INT][`HWRC_INT_GLOBAL]
                       && |(irq_request & cfg[CFG_INT][`HWRC_INT_EN_MSB:`HWRC_INT_EN_LSB])
                       && !stack_full;
    // ============================================================
    // phase sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= hwrc_pkg::HWRC_OPTLOAD;
            cnt   <= 11'h000;
            cause <= hwrc_pkg::HWRC_CAUSE_FULL;
        end else if (go_full) begin
            // a held-low pin keeps restarting the option load
            state <= hwrc_pkg::HWRC_OPTLOAD;
            cnt   <= 11'h000;
            cause <= hwrc_pkg::HWRC_CAUSE_FULL;
        end else begin
            unique case (state)
                hwrc_pkg::HWRC_OPTLOAD: begin
                    if (cnt == OPT_LAST) begin
                        state <= hwrc_pkg::HWRC_STARTUP;
                        cnt   <= 11'h000;
                    end else begin
                        cnt <= cnt + 11'h001;
                    end
                end
                hwrc_pkg::HWRC_STARTUP: begin
                    if (sst_done) begin
                        state <= irq_go ? hwrc_pkg::HWRC_IRQ_DELAY : hwrc_pkg::HWRC_RUN;
                        cnt   <= 11'h000;
                    end else if (osc_run) begin
                        cnt <= cnt + 11'h001;
                    end
                end
                hwrc_pkg::HWRC_RUN: begin
                    if (go_sleep) begin
                        state <= hwrc_pkg::HWRC_SLEEP;
                    end
                end
                hwrc_pkg::HWRC_SLEEP: begin
                    if (go_warm) begin
                        state <= hwrc_pkg::HWRC_STARTUP;
                        cause <= hwrc_pkg::HWRC_CAUSE_WARM;
                    end else if (wake_irq) begin
                        state <= hwrc_pkg::HWRC_STARTUP;
                        cause <= hwrc_pkg::HWRC_CAUSE_IRQ;
                    end else if (wake_port) begin
                        state <= hwrc_pkg::HWRC_STARTUP;
                        cause <= hwrc_pkg::HWRC_CAUSE_NEXT;
                    end
                end
                hwrc_pkg::HWRC_IRQ_DELAY: begin
                    state <= hwrc_pkg::HWRC_RUN;
                end
                default: begin
                    state <= hwrc_pkg::HWRC_OPTLOAD;
                end
            endcase
        end
    end
    // ============================================================
    // interrupts already pending at sleep entry are masked off as wake sources
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_mask <= 3'h0;
        end else if (go_sleep) begin
            irq_mask <= irq_request;
        end
    end
    // ============================================================
    // status flags; a set beats a clear in the same cycle, except that the clear pin in sleep beats a watchdog overflow
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sleep_flag           <= 1'b0;
            watchdog_expiry_flag <= 1'b0;
        end else if (ext_clr) begin
            if (state == hwrc_pkg::HWRC_SLEEP) begin
                watchdog_expiry_flag <= 1'b0;
            end
        end else if (state == hwrc_pkg::HWRC_SLEEP && watchdog_overflow) begin
            watchdog_expiry_flag <= 1'b1;
        end else if (state == hwrc_pkg::HWRC_RUN) begin
            if (watchdog_overflow) begin
                watchdog_expiry_flag <= 1'b1;
            end else if (sleep_instruction) begin
                sleep_flag           <= 1'b1;
                watchdog_expiry_flag <= 1'b0;
            end else if (clear_watchdog_instruction) begin
                sleep_flag <= 1'b0;
            end
        end
    end
    // ============================================================
    // oscillator gate and core hold
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_run   <= 1'b1;
            core_hold <= 1'b1;
        end else begin
            if (go_sleep) begin
                osc_run <= 1'b0;
            end else if (go_full || go_warm || wake_irq || wake_port) begin
                osc_run <= 1'b1;
            end
            if (go_full || go_sleep) begin
                core_hold <= 1'b1;
            end else if ((sst_done && !irq_go) || state == hwrc_pkg::HWRC_IRQ_DELAY) begin
                core_hold <= 1'b0;
            end
        end
    end
    // ============================================================
    // strobes to core and watchdog; own-oscillator watchdog restarts on sleep entry
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            full_reset     <= 1'b1;
            warm_reset     <= 1'b0;
            watchdog_clear <= 1'b1;
            resume_next    <= 1'b0;
            irq_ack        <= 1'b0;
        end else begin
            full_reset     <= go_full;
            warm_reset     <= go_warm;
            watchdog_clear <= go_full || (go_sleep && ctrl[`HWRC_CTRL_WDOSC])
                              || (state == hwrc_pkg::HWRC_RUN && clear_watchdog_instruction);
            resume_next    <= sst_done && !irq_go && (cause == hwrc_pkg::HWRC_CAUSE_NEXT
                              || cause == hwrc_pkg::HWRC_CAUSE_IRQ);
            irq_ack        <= state == hwrc_pkg::HWRC_IRQ_DELAY;
        end
    end
    // ============================================================
    // reset-state registers, one generate entry each; bus writes ignored in sleep
    for (genvar i = 0; i < N_CFG; i++) begin : g_cfg
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                cfg[i] <= CFG_RST[i];
            end else if (go_full) begin
                cfg[i] <= CFG_RST[i];
            end else if (go_warm && i == CFG_PCLOW) begin
                cfg[i] <= CFG_RST[i];
            end else if (wr_pend && state != hwrc_pkg::HWRC_SLEEP
                         && addr_q == 8'(`HWRC_OFF_CFG_BASE + 4 * i)) begin
                cfg[i] <= hwdata[7:0] & CFG_MASK[i];
            end
        end
    end
    // ============================================================
    // wake configuration; survives every reset except power-up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= `HWRC_RST_CTRL;
        end else if (wr_pend && addr_q == `HWRC_OFF_CTRL) begin
            ctrl <= hwdata[8:0];
        end
    end
    // ============================================================
    // AHB-Lite slave: zero-wait writes; one read wait so a read after a write sees it
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_q == `HWRC_OFF_CTRL) begin
            rd_mux = {23'h000000, ctrl};
        end else if (addr_q == `HWRC_OFF_STATUS) begin
            rd_mux = {25'h0000000, cause, state, sleep_flag, watchdog_expiry_flag};
        end
        for (int k = 0; k < N_CFG; k++) begin
            if (addr_q == 8'(`HWRC_OFF_CFG_BASE + 4 * k)) begin
                rd_mux = {24'h000000, cfg[k]};
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            if (rd_pend) begin
                hrdata    <= rd_mux;
                hreadyout <= 1'b1;
            end else if (hsel && htrans[1] && hready) begin
                // unmapped words read zero; any address with bits [31:8] set is taken as offset 8'hfc
                addr_q    <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hfc;
                wr_pend   <= hwrite;
                rd_pend   <= !hwrite;
                hreadyout <= hwrite;
            end
        end
    end
    // ============================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [11:0] sst_seen;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sst_seen <= 12'h000;
        end else if (state == hwrc_pkg::HWRC_STARTUP && osc_run) begin
            sst_seen <= sst_seen + 12'h001;
        end else if (state != hwrc_pkg::HWRC_STARTUP) begin
            sst_seen <= 12'h000;
        end
    end
    sequence s_enter_sleep;
        go_sleep ##1 state == hwrc_pkg::HWRC_SLEEP;
    endsequence
    property p_sleep_flags;
        s_enter_sleep |-> sleep_flag && !watchdog_expiry_flag && !osc_run;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep entry flags or oscillator wrong");
    property p_osc_off;
        state == hwrc_pkg::HWRC_SLEEP && !ext_clr && !watchdog_overflow && !wake_irq && !wake_port
            |=> !osc_run && state == hwrc_pkg::HWRC_SLEEP;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator ran or left sleep unprompted");
    property p_wd_clear;
        go_sleep && ctrl[`HWRC_CTRL_WDOSC] |=> watchdog_clear ##1 !watchdog_clear;
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared on sleep entry");
    property p_clrwdt;
        state == hwrc_pkg::HWRC_RUN && clear_watchdog_instruction && !sleep_instruction && !go_full
            |=> !sleep_flag;
    endproperty
    a_clrwdt: assert property (p_clrwdt) else $error("clear-watchdog left sleep flag set");
    property p_warm;
        go_warm |=> warm_reset && !full_reset && sleep_flag && watchdog_expiry_flag
            && cfg[CFG_PCLOW] == 8'h00 && $stable(cfg[CFG_TIMER]);
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset wrong");
    property p_wdt_run;
        state == hwrc_pkg::HWRC_RUN && watchdog_overflow && !ext_clr
            |=> full_reset && watchdog_expiry_flag && state == hwrc_pkg::HWRC_OPTLOAD;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("running overflow did not reset fully");
    property p_sst_len;
        $fell(core_hold) || $rose(irq_ack) |-> $past(sst_seen, 1) >= 12'(SST_CYCLES - 1)
            || $past(sst_seen, 2) >= 12'(SST_CYCLES - 1);
    endproperty
    a_sst_len: assert property (p_sst_len) else $error("resumed before start-up delay");
    property p_full_load;
        go_full |=> cfg[CFG_TIMER] == `HWRC_RST_TIMER && cfg[CFG_INT] == `HWRC_RST_INT;
    endproperty
    a_full_load: assert property (p_full_load) else $error("full reset values not loaded");
    property p_irq_delay;
        sst_done && irq_go |=> core_hold ##1 irq_ack && !core_hold;
    endproperty
    a_irq_delay: assert property (p_irq_delay) else $error("interrupt wake not delayed one cycle");
    property p_masked_irq;
        state == hwrc_pkg::HWRC_SLEEP && !ext_clr && !watchdog_overflow && pa_fall == 8'h00
            && (irq_request & ~irq_mask) == 3'h0 |=> state == hwrc_pkg::HWRC_SLEEP;
    endproperty
    a_masked_irq: assert property (p_masked_irq) else $error("pending interrupt woke device");
endmodule
`default_nettype wire

//--- verif/hwrc_pins.sv
// pin-side partner: external clear pin and port A lines, all pulled up.
// assumes the bench raises pull-low requests just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module hwrc_pins #(
    parameter int SETTLE = 1
) (
    input  wire logic       sys_clk,
    input  wire logic       pin_req,
    input  wire logic [7:0] port_req,
    output var  logic       external_clear_pin_n,
    output var  logic [7:0] port_a_in
);
    // ============================================================
    // pull-ups win unless a line is pulled low; edges land off the clock
    initial begin
        external_clear_pin_n = 1'b1;
        port_a_in            = 8'hff;
    end
    always @(posedge sys_clk) begin
        external_clear_pin_n <= #SETTLE !pin_req;
        port_a_in            <= #SETTLE ~port_req;
    end
endmodule
`default_nettype wire

//--- verif/hwrc_tb_top.sv
// bench for the sleep, wake-up and reset controller.
// assumes hwrc_top with a short option load; the pin model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module hwrc_tb_top;
    logic sys_clk = 0, rst = 1, hsel, hwrite, hreadyout, hresp, pin_req, stack_full;
    logic sleep_instruction, clear_watchdog_instruction, watchdog_overflow;
    logic osc_run, core_hold, full_reset, warm_reset, watchdog_clear, resume_next;
    logic irq_ack, sleep_flag, watchdog_expiry_flag, external_clear_pin_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, irq_request;
    logic [7:0]  port_req, port_a_in;
    wire         hready = hreadyout;
    int          bad_count = 0, tests_run = 0, n_res = 0, n_irq = 0, n_warm = 0, n_wdc = 0, cyc, w, w2;
    localparam logic [7:0] RV [7] = '{8'h08, 8'h40, 8'h08, 8'h00, 8'hff, 8'hff, 8'h00};

    hwrc_top #(.OPT_CYCLES(2)) dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .external_clear_pin_n, .port_a_in, .sleep_instruction,
        .clear_watchdog_instruction, .watchdog_overflow, .irq_request, .stack_full, .osc_run,
        .core_hold, .full_reset, .warm_reset, .watchdog_clear, .resume_next, .irq_ack, .sleep_flag,
        .watchdog_expiry_flag);
    hwrc_pins pins (.sys_clk, .pin_req, .port_req, .external_clear_pin_n, .port_a_in);

    // ============================================================
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // pulse counters, sampled mid-cycle where outputs are settled
    always @(negedge sys_clk) begin
        n_res  += (resume_next === 1'b1);
        n_irq  += (irq_ack === 1'b1);
        n_warm += (warm_reset === 1'b1);
        n_wdc  += (watchdog_clear === 1'b1);
    end

    // ============================================================
    // shared tasks
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // single AHB-Lite word transfer; hready seen at negedge equals its value at the next edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr;
        do begin @(negedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        @(posedge sys_clk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do begin @(negedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        @(posedge sys_clk);
        if (n >= 50) begin bad_count++; finish_test; end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk("register", e, rd);
        chk("hresp", 0, hresp);
    endtask

    task idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // bounded wait for the core to be released, counting cycles
    task wait_run;
        cyc = 0;
        while (core_hold !== 1'b0 && cyc < 4000) begin @(negedge sys_clk); cyc++; end
        if (cyc >= 4000) begin bad_count++; finish_test; end
        idle(2);
    endtask

    task go_sleep;
        @(posedge sys_clk) sleep_instruction <= 1'b1;
        @(posedge sys_clk) sleep_instruction <= 1'b0;
        @(negedge sys_clk);
        chk("osc_run", 0, osc_run);
        chk("sleep_flag", 1, sleep_flag);
        chk("expiry_flag", 0, watchdog_expiry_flag);
    endtask

    task flags(input logic e, input logic s);
        chk("expiry_flag", e, watchdog_expiry_flag);
        chk("sleep_flag", s, sleep_flag);
    endtask

    task regs_full;
        for (int i = 0; i < 7; i++) rdchk(8'h08 + 8'(4 * i), {24'h0, RV[i]});
    endtask

    // ============================================================
    // scenarios
    task t_reset;
        flags(0, 0);
        wait_run;
        chk("startup", 1, cyc >= 1026 && cyc <= 1040);
        regs_full;
        rdchk(8'h04, 32'h08);
        ahb(1'b1, 8'h40, 32'h5a);
        rdchk(8'h40, 0);
        $display("test reset done");
    endtask

    // disabled bit ignored, enabled bit wakes; writes frozen in sleep
    task t_port;
        ahb(1'b1, 8'h00, 32'h108);
        rdchk(8'h00, 32'h108);
        w = n_wdc;
        go_sleep;
        @(posedge sys_clk);
        chk("watchdog_clear", w + 1, n_wdc);
        ahb(1'b1, 8'h08, 32'h9f);
        @(posedge sys_clk) port_req <= 8'h01;
        idle(20);
        chk("osc_run", 0, osc_run);
        w = n_res;
        @(posedge sys_clk) port_req <= 8'h09;
        wait_run;
        chk("wake_delay", 1, cyc >= 1024 && cyc <= 1034);
        chk("resume_next", w + 1, n_res);
        port_req <= 8'h00;
        rdchk(8'h08, 32'h08);
        $display("test port done");
    endtask

    // pending request blocked; enabled one acknowledged; stack full resumes
    task t_irq;
        ahb(1'b1, 8'h14, 32'h0f);
        irq_request <= 3'b010;
        go_sleep;
        idle(20);
        chk("osc_run", 0, osc_run);
        w = n_irq;
        @(posedge sys_clk) irq_request <= 3'b011;
        wait_run;
        chk("irq_ack", w + 1, n_irq);
        irq_request <= 3'b000;
        go_sleep;
        w = n_res;
        @(posedge sys_clk) begin stack_full <= 1'b1; irq_request <= 3'b001; end
        wait_run;
        chk("resume_next", w + 1, n_res);
        irq_request <= 3'b000;
        stack_full <= 1'b0;
        ahb(1'b1, 8'h14, 32'h01);
        go_sleep;
        w = n_res;
        @(posedge sys_clk) irq_request <= 3'b001;
        wait_run;
        chk("resume_next", w + 1, n_res);
        irq_request <= 3'b000;
        $display("test irq done");
    endtask

    // overflow asleep is warm, then overflow running is full
    task t_wdog;
        ahb(1'b1, 8'h08, 32'h10);
        ahb(1'b1, 8'h20, 32'h55);
        go_sleep;
        w = n_warm;
        w2 = n_res;
        @(posedge sys_clk) watchdog_overflow <= 1'b1;
        @(posedge sys_clk) watchdog_overflow <= 1'b0;
        wait_run;
        chk("warm_reset", w + 1, n_warm);
        chk("resume_next", w2, n_res);
        flags(1, 1);
        rdchk(8'h08, 32'h10);
        rdchk(8'h20, 32'h00);
        @(posedge sys_clk) watchdog_overflow <= 1'b1;
        @(posedge sys_clk) watchdog_overflow <= 1'b0;
        idle(3);
        chk("core_hold", 1, core_hold);
        wait_run;
        flags(1, 1);
        regs_full;
        @(posedge sys_clk) clear_watchdog_instruction <= 1'b1;
        @(posedge sys_clk) clear_watchdog_instruction <= 1'b0;
        @(negedge sys_clk);
        chk("sleep_flag", 0, sleep_flag);
        $display("test watchdog done");
    endtask

    task t_pin;
        ahb(1'b1, 8'h08, 32'h10);
        go_sleep;
        @(posedge sys_clk) pin_req <= 1'b1;
        idle(6);
        chk("full_reset", 1, full_reset);
        @(posedge sys_clk) pin_req <= 1'b0;
        idle(4);
        wait_run;
        flags(0, 1);
        rdchk(8'h08, 32'h08);
        $display("test pin done");
    endtask

    // ============================================================
    // main sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, irq_request, port_req} = '0;
        {sleep_instruction, clear_watchdog_instruction, watchdog_overflow, stack_full, pin_req} = '0;
        hsize = 3'b010;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_port;
        t_irq;
        t_wdog;
        t_pin;
        finish_test;
    end
endmodule
`default_nettype wire
